// ===== core/pcl_loader.sv
// preload loader: fetches port config words and exposes them
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`include "pcl_cfg.svh"
`default_nettype none
module pcl_loader
  import pcl_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // word fetch port toward the serial memory controller
  output var  logic        mem_req_o,
  output var  logic [8:0]  mem_addr_o,
  input  wire logic        mem_ack_i,
  input  wire logic        mem_hit_i,
  input  wire logic [15:0] mem_data_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // loaded per-port fields
  output var  pcl_vc_s     vc_cfg_o [`PCL_NVC],
  output var  pcl_pm_s     pm_cfg_o [`PCL_NPM],
  output var  logic        cfg_valid_o
);
  localparam int NW = `PCL_NWORDS;

  // word index to memory word address: VC words first, then PM words
  function automatic logic [8:0] word_addr(input logic [3:0] idx);
    if (idx < 4'(`PCL_NVC)) begin
      word_addr = `PCL_VC_BASE + 9'(idx) * `PCL_STRIDE; // R3 R10
    end else begin
      word_addr = `PCL_PM_BASE
                + 9'(idx - 4'(`PCL_NVC)) * `PCL_STRIDE; // R9 R11
    end
  endfunction : word_addr

  // reset image of one port's fields
  function automatic pcl_vc_s vc_default();
    vc_default.vc1_max_slot = `PCL_RST_SLOT;
    vc_default.tc_vc1_map   = `PCL_RST_TCMAP;
  endfunction : vc_default

  function automatic pcl_pm_s pm_default();
    pm_default.l1_power_option_bits      = `PCL_RST_L1OPT;
    pm_default.sw_pm_l1_sub1_support     = 1'b0;
    pm_default.active_pm_l1_sub1_support = 1'b0;
    pm_default.l1_substates_supported    = 1'b0;
    pm_default.ltssm_ctl                 = `PCL_RST_LTSSM;
  endfunction : pm_default

  pcl_state_e      st_r, st_nxt;
  logic [3:0]      idx_r, idx_nxt;
  logic [NW-1:0]   hit_r, hit_nxt;
  logic            valid_r, valid_nxt;
  logic            req_r, req_nxt;
  logic [8:0]      addr_r, addr_nxt;
  pcl_vc_s         vc_r [`PCL_NVC];
  pcl_vc_s         vc_nxt [`PCL_NVC];
  pcl_pm_s         pm_r [`PCL_NPM];
  pcl_pm_s         pm_nxt [`PCL_NPM];
  logic            reload;
  logic            take;
  logic [3:0]      pidx;

  // a fetch completes on the cycle the controller acknowledges
  assign take = (st_r == PCL_WAIT) && mem_ack_i;
  assign pidx = idx_r - 4'(`PCL_NVC);

  // loader sequence and field capture
  always_comb begin
    st_nxt    = st_r;
    idx_nxt   = idx_r;
    hit_nxt   = hit_r;
    valid_nxt = valid_r;
    req_nxt   = req_r;
    addr_nxt  = addr_r;
    vc_nxt    = vc_r;
    pm_nxt    = pm_r;
    unique case (st_r)
      PCL_IDLE: begin
        idx_nxt  = 4'h0;
        hit_nxt  = '0;
        addr_nxt = word_addr(4'h0);
        req_nxt  = 1'b1;
        st_nxt   = PCL_REQ;
      end
      PCL_REQ: begin
        st_nxt = PCL_WAIT;
      end
      PCL_WAIT: begin
        if (take) begin
          if (mem_hit_i) begin
            hit_nxt[idx_r] = 1'b1;
            if (idx_r < 4'(`PCL_NVC)) begin
              vc_nxt[idx_r[2:0]].vc1_max_slot = mem_data_i[6:0];  // R1
              vc_nxt[idx_r[2:0]].tc_vc1_map   = mem_data_i[15:8]; // R2
            end else begin
              pm_nxt[pidx[2:0]].l1_power_option_bits =
                mem_data_i[3:0]; // R4
              pm_nxt[pidx[2:0]].sw_pm_l1_sub1_support =
                mem_data_i[4]; // R5
              pm_nxt[pidx[2:0]].active_pm_l1_sub1_support =
                mem_data_i[5]; // R6
              pm_nxt[pidx[2:0]].l1_substates_supported =
                mem_data_i[6]; // R7
              pm_nxt[pidx[2:0]].ltssm_ctl = mem_data_i[15:8]; // R8
            end
          end
          // an absent word leaves the defaults in place
          if (idx_r == 4'(NW - 1)) begin
            req_nxt   = 1'b0;
            valid_nxt = 1'b1; // R12
            st_nxt    = PCL_DONE;
          end else begin
            idx_nxt  = idx_r + 4'h1;
            addr_nxt = word_addr(idx_r + 4'h1);
            st_nxt   = PCL_REQ;
          end
        end
      end
      PCL_DONE: begin
        // a reload restores defaults first so stale words never linger
        if (reload) begin
          valid_nxt = 1'b0; // R12
          for (int i = 0; i < `PCL_NVC; i++) begin
            vc_nxt[i] = vc_default(); // R13
          end
          for (int i = 0; i < `PCL_NPM; i++) begin
            pm_nxt[i] = pm_default(); // R13
          end
          st_nxt = PCL_IDLE;
        end
      end
    endcase
  end

  // loader registers; reset starts a fresh load
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_r    <= PCL_IDLE;
      idx_r   <= 4'h0;
      hit_r   <= '0;
      valid_r <= 1'b0;
      req_r   <= 1'b0;
      addr_r  <= `PCL_VC_BASE;
      for (int i = 0; i < `PCL_NVC; i++) begin
        vc_r[i] <= vc_default(); // R13
      end
      for (int i = 0; i < `PCL_NPM; i++) begin
        pm_r[i] <= pm_default(); // R13
      end
    end else begin
      st_r    <= st_nxt;
      idx_r   <= idx_nxt;
      hit_r   <= hit_nxt;
      valid_r <= valid_nxt;
      req_r   <= req_nxt;
      addr_r  <= addr_nxt;
      vc_r    <= vc_nxt;
      pm_r    <= pm_nxt;
    end
  end

  assign mem_req_o   = req_r;
  assign mem_addr_o  = addr_r;
  assign vc_cfg_o    = vc_r;
  assign pm_cfg_o    = pm_r;
  assign cfg_valid_o = valid_r;

  // raw word shadow for software readback
  logic [15:0] raw_rdata;

  pcl_word_mem u_mem (
    .mclk    (mclk),
    .we      (take),
    .waddr   (idx_r),
    .wdata   (mem_hit_i ? mem_data_i : 16'h0000),
    .raddr   (wb_adr_i[5:2]),
    .rdata_r (raw_rdata)
  );

  // bus slave: phase 1 decodes and writes, phase 2 acks with read data
  logic        ph_r, ph_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic        hit_raw;
  logic [31:0] status;

  assign hit_raw = (wb_adr_i[7:6] == 2'(`PCL_REG_RAW >> 6))
                && (wb_adr_i[5:2] < 4'(NW));
  assign reload  = ph_r && wb_we_i && wb_sel_i[0]
                && (wb_adr_i == `PCL_REG_CTRL)
                && wb_dat_i[`PCL_CTRL_RELOAD];

  // status word: done, busy, per-word presence mask
  always_comb begin
    status = 32'h0000_0000;
    status[`PCL_ST_DONE] = valid_r;
    status[`PCL_ST_BUSY] = (st_r != PCL_DONE);
    status[`PCL_ST_MASK_LO +: NW] = hit_r;
  end

  always_comb begin
    ph_nxt  = 1'b0;
    ack_nxt = 1'b0;
    dat_nxt = 32'h0000_0000;
    if (wb_cyc_i && wb_stb_i && !ph_r && !ack_r) begin
      ph_nxt = 1'b1;
    end
    if (ph_r) begin
      ack_nxt = 1'b1;
      // unmapped addresses and writes return zero
      if (!wb_we_i) begin
        if (wb_adr_i == `PCL_REG_STATUS) begin
          dat_nxt = status;
        end else if (hit_raw) begin
          dat_nxt = {16'h0000, raw_rdata};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ph_r  <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ph_r  <= ph_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
endmodule : pcl_loader
`default_nettype wire

// ===== core/pcl_word_mem.sv
// shadow memory of the raw preload words, registered read
`default_nettype none
module pcl_word_mem (
  input  wire logic        mclk,
  input  wire logic        we,
  input  wire logic [3:0]  waddr,
  input  wire logic [15:0] wdata,
  input  wire logic [3:0]  raddr,
  output var  logic [15:0] rdata_r
);
  logic [15:0] mem_r [16];
  logic [15:0] rdata_nxt;

  // read mux, registered below
  always_comb begin
    rdata_nxt = mem_r[raddr];
  end

  // no reset on storage; a word read back before its first fetch is unknown
  always_ff @(posedge mclk) begin
    if (we) begin
      mem_r[waddr] <= wdata;
    end
    rdata_r <= rdata_nxt;
  end
endmodule : pcl_word_mem
`default_nettype wire

// ===== include/pcl_cfg.svh
// constants of the port configuration preload loader
// What this block does
// R1: VC word bits 6:0 load config 15Ch bits 22:16, VC1 highest time slot.
// R2: VC word bits 15:8 load config 160h bits 7:0, TC-to-VC1 map.
// R3: VC words for ports 1 to 5 sit at 102h, 104h, 106h, 108h, 10Ah.
// R4: PM word bits 3:0 load config 98h bits 27:24, L1 option bits.
// R5: PM word bit 4 loads config 244h bit 1, L1.1 software PM support.
// R6: PM word bit 5 loads config 244h bit 3, L1.1 active-state PM support.
// R7: PM word bit 6 loads config 244h bit 4, L1 substates supported.
// R8: PM word bits 15:8 load config 33Ch bits 7:0, link training control.
// R9: PM words for ports 0 to 3 sit at 110h, 112h, 114h, 116h.
// R10: VC word for port 0 sits at 100h with the same layout.
// R11: PM word for port 4 sits at 118h.
// R12: loaded fields count as valid only after all present words are loaded.
// R13: bits without a word mapping, or absent words, keep reset defaults.
`ifndef PCL_CFG_SVH
`define PCL_CFG_SVH
// preload memory word addresses
`define PCL_VC_BASE      9'h100
`define PCL_PM_BASE      9'h110
`define PCL_STRIDE       9'h002
`define PCL_NVC          6
`define PCL_NPM          5
`define PCL_NWORDS       11
// config space targets of the loaded fields
`define PCL_CFG_VC_SLOT  12'h15C
`define PCL_CFG_TC_MAP   12'h160
`define PCL_CFG_L1_OPT   12'h098
`define PCL_CFG_L1_SUB   12'h244
`define PCL_CFG_LTSSM    12'h33C
// reset defaults of the loaded fields
`define PCL_RST_SLOT     7'h00
`define PCL_RST_TCMAP    8'h00
`define PCL_RST_L1OPT    4'h0
`define PCL_RST_LTSSM    8'h00
// register byte offsets on the bus
`define PCL_REG_CTRL     8'h00
`define PCL_REG_STATUS   8'h04
`define PCL_REG_RAW      8'h40
`define PCL_CTRL_RELOAD  0
`define PCL_ST_DONE      0
`define PCL_ST_BUSY      1
`define PCL_ST_MASK_LO   16
`endif

// ===== include/pcl_pkg.sv
// types of the port configuration preload loader
`default_nettype none
package pcl_pkg;
  typedef struct packed {
    logic [7:0] tc_vc1_map;
    logic [6:0] vc1_max_slot;
  } pcl_vc_s;
  typedef struct packed {
    logic [7:0] ltssm_ctl;
    logic       l1_substates_supported;
    logic       active_pm_l1_sub1_support;
    logic       sw_pm_l1_sub1_support;
    logic [3:0] l1_power_option_bits;
  } pcl_pm_s;
  typedef enum logic [1:0] {
    PCL_IDLE = 2'b00,
    PCL_REQ  = 2'b01,
    PCL_WAIT = 2'b11,
    PCL_DONE = 2'b10
  } pcl_state_e;
endpackage : pcl_pkg
`default_nettype wire

// ===== tb/pcl_loader_sva.sv
// assertions on the preload loader's ports
`include "pcl_cfg.svh"
`default_nettype none
module pcl_loader_sva
  import pcl_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        mem_req_o,
  input wire logic [8:0]  mem_addr_o,
  input wire logic        mem_ack_i,
  input wire logic        mem_hit_i,
  input wire logic [15:0] mem_data_i,
  input wire pcl_vc_s     vc_cfg_o [`PCL_NVC],
  input wire pcl_pm_s     pm_cfg_o [`PCL_NPM],
  input wire logic        cfg_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] dq_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // word as taken at the ack edge
  always_ff @(posedge mclk) dq_r <= mem_data_i;
  // a fetch completing at one word address
  sequence s_take(a, h);
    mem_req_o && mem_ack_i && mem_hit_i == h && mem_addr_o == a;
  endsequence
  AST_VC_SLOT: assert property (
    s_take(9'h102, 1'b1) |=> vc_cfg_o[1].vc1_max_slot == dq_r[6:0])
    else $error("vc1 slot of port 1 wrong");
  AST_TC_MAP: assert property (
    s_take(9'h100, 1'b1) |=> vc_cfg_o[0].tc_vc1_map == dq_r[15:8])
    else $error("tc map of port 0 wrong");
  AST_L1_OPT: assert property (
    s_take(9'h116, 1'b1) |=> pm_cfg_o[3].l1_power_option_bits == dq_r[3:0])
    else $error("l1 options of port 3 wrong");
  AST_L1_SUB: assert property (
    s_take(9'h110, 1'b1) |=> {pm_cfg_o[0].l1_substates_supported,
    pm_cfg_o[0].active_pm_l1_sub1_support,
    pm_cfg_o[0].sw_pm_l1_sub1_support} == dq_r[6:4])
    else $error("l1 substate bits of port 0 wrong");
  AST_LAST: assert property (
    s_take(9'h118, 1'b1) |=> pm_cfg_o[4].ltssm_ctl == dq_r[15:8]
    && cfg_valid_o && !mem_req_o)
    else $error("last word not finishing the load");
  AST_ABSENT: assert property (
    s_take(9'h10A, 1'b0) |=> vc_cfg_o[5] == 15'h0000)
    else $error("absent word changed port 5 fields");
  AST_VALID: assert property (
    $rose(cfg_valid_o) |-> $past(mem_ack_i) && $past(mem_addr_o) == 9'h118)
    else $error("valid rose before the last word");
  AST_ADDR_HOLD: assert property (
    mem_req_o && !mem_ack_i |=> $stable(mem_addr_o))
    else $error("fetch address moved before ack");
endmodule : pcl_loader_sva
bind pcl_loader pcl_loader_sva chk_u (.mclk, .rst_n, .mem_req_o, .mem_addr_o,
  .mem_ack_i, .mem_hit_i, .mem_data_i, .vc_cfg_o, .pm_cfg_o, .cfg_valid_o);
`default_nettype wire

// ===== tb/pcl_mem_model.sv
// behavioural preload word memory behind the fetch port
`default_nettype none
module pcl_mem_model (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              req,
  input  wire logic [8:0]        addr,
  input  wire logic [10:0][15:0] words,
  input  wire logic [10:0]       present,
  input  wire logic [3:0]        dly,
  output var  logic              ack,
  output var  logic              hit,
  output var  logic [15:0]       data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r;
  logic [3:0] idx;
  // vc words from 100h, pm words from 110h, two apart
  assign idx = addr[4] ? 4'(addr[3:1]) + 4'h6 : 4'(addr[3:1]);
  // inverse outside the ack cycle so stale data never matches by luck
  assign data = ack ? words[idx] : ~words[idx];
  assign hit  = ack ? present[idx] : ~present[idx];
  // ack after dly waits; never in the cycle after an address change
  always_ff @(posedge mclk) begin
    if (!rst_n || !req || ack) begin
      ack   <= 1'b0;
      cnt_r <= 4'h0;
    end else if (cnt_r >= dly) begin
      ack <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end
endmodule : pcl_mem_model
`default_nettype wire

// ===== tb/test_port_config_preload_map.sv
// self-checking bench of the preload loader
`include "pcl_cfg.svh"
`default_nettype none
module test_port_config_preload_map
  import pcl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rd, q, seed = 32'hd45a_db05;
  logic [10:0][15:0] words = '0, nw;
  logic [10:0] present = '0, np;
  logic [3:0]  dly = 4'h1;
  logic        req, ack, hit, ack_o, valid;
  logic [8:0]  maddr;
  logic [15:0] mdata;
  pcl_vc_s     vc [`PCL_NVC];
  pcl_pm_s     pm [`PCL_NPM];
  int bad_count = 0, n_tests = 0;
  always #4 mclk = ~mclk;
  pcl_loader dut_u (.mclk, .rst_n, .mem_req_o(req), .mem_addr_o(maddr),
    .mem_ack_i(ack), .mem_hit_i(hit), .mem_data_i(mdata), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack_o), .vc_cfg_o(vc),
    .pm_cfg_o(pm), .cfg_valid_o(valid));
  pcl_mem_model mdl_u (.mclk, .rst_n, .req, .addr(maddr), .words,
    .present, .dly, .ack, .hit, .data(mdata));
  function automatic logic [31:0] lfsr_f(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_f
  // both word kinds keep bits 15:8 and 6:0, absent gives zero
  function automatic logic [31:0] exp_f(input logic [15:0] w, input logic h);
    return h ? {17'h0_0000, w[15:8], w[6:0]} : 32'h0000_0000;
  endfunction : exp_f
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask : chk
  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
    q = 'x;
    // no cycle count assumed: only the watchdog ends a missing answer
    do begin
      @(posedge mclk);
    end while (ack_o !== 1'b1);
    q = rd;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  // cut a hang short
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    conclude();
  end
  // rounds: all present, random present, none present
  initial begin
    repeat (12) @(posedge mclk);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 11; k++) begin
        seed = lfsr_f(seed);
        nw[k] = seed[15:0];
      end
      np = (r == 0) ? 11'h7FF : (r == 1) ? seed[26:16] : 11'h000;
      words <= nw;
      present <= np;
      dly <= 4'(r + 1);
      if (r == 0) rst_n <= 1'b1;
      else wb(1'b1, `PCL_REG_CTRL, 32'h0000_0001);
      repeat (400) begin
        @(posedge mclk);
        if (valid === 1'b1) break;
      end
      chk("valid", 32'h1, 32'(valid));
      for (int p = 0; p < 6; p++) chk("vc", exp_f(nw[p], np[p]), 32'(vc[p]));
      for (int p = 0; p < 5; p++) chk("pm", exp_f(nw[6+p], np[6+p]), 32'(pm[p]));
      wb(1'b0, `PCL_REG_STATUS, 32'h0);
      chk("status", {5'h00, np, 14'h0000, 2'h1}, q);
      // words 0, 5 and 10: first vc, last vc and last pm word
      wb(1'b0, 8'(`PCL_REG_RAW + 20 * r), 32'h0);
      chk("raw", np[5*r] ? {16'h0000, nw[5*r]} : 32'h0, q);
      wb(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0000_0000, q);
      $display("round %0d done", r);
    end
    conclude();
  end
endmodule : test_port_config_preload_map
`default_nettype wire
